// file: hw/rail_seq_pkg.sv
package rail_seq_pkg;
    localparam int CLK_HZ = 10000000;
    localparam int CHANNELS = 4;
    // Step delay programming range, 8-bit code
    localparam real STEP_DELAY_MIN_MS = 0.25;
    localparam real STEP_DELAY_MAX_MS = 25.0;
    localparam int STEP_UNIT_CYCLES = $rtoi(STEP_DELAY_MIN_MS * CLK_HZ / 1000.0);
    localparam int STEP_CODE_MAX = $rtoi(STEP_DELAY_MAX_MS / STEP_DELAY_MIN_MS);
    localparam int TIMER_W = 20;
    // Default regulation window in milliseconds
    localparam real REG_WINDOW_MS = 12.4;
    localparam int REG_WINDOW_CYCLES = $rtoi(REG_WINDOW_MS * CLK_HZ / 1000.0);
    // Monitor hold times in microseconds
    localparam real HOLD_RISE_US = 1.6;
    localparam real HOLD_FALL_US = 1.0;
    localparam int HOLD_RISE_CYCLES = $rtoi($ceil(HOLD_RISE_US * CLK_HZ / 1.0e6));
    localparam int HOLD_FALL_CYCLES = $rtoi($ceil(HOLD_FALL_US * CLK_HZ / 1.0e6));
    localparam int HOLD_W = 5;
    // Fault propagation bound in microseconds
    localparam real FAULT_PROP_US = 4.3;
    localparam int FAULT_PROP_CYCLES = $rtoi($floor(FAULT_PROP_US * CLK_HZ / 1.0e6));
    localparam logic [1:0] FIRST_CH = 2'h0;
    localparam logic [1:0] LAST_CH = 2'h3;
endpackage

// file: hw/rail_filter_if.sv
`timescale 1ns/100ps
`default_nettype none
interface rail_filter_if;
    logic [3:0] railRaw;
    logic [3:0] railInReg;
    modport filt (input railRaw, output railInReg);
    modport user (output railRaw, input railInReg);
endinterface
`default_nettype wire

// file: hw/rail_hold_filter.sv
`timescale 1ns/100ps
`default_nettype none
module rail_hold_filter (
    // Clock and reset
    input  wire logic  clk,
    input  wire logic  resetn,
    // Monitor levels
    rail_filter_if.filt mon
);
    typedef struct packed {
        logic [3:0]        sync1;
        logic [3:0]        sync2;
        logic [3:0]        state;
        logic [3:0][rail_seq_pkg::HOLD_W-1:0] cnt;
    } filt_state_t;

    filt_state_t st_reg;
    filt_state_t st_next;

    assign mon.railInReg = st_reg.state;

    always_comb begin
        st_next = st_reg;
        st_next.sync1 = mon.railRaw;
        st_next.sync2 = st_reg.sync1;
        for (int i = 0; i < 4; i++) begin
            if (st_reg.sync2[i] == st_reg.state[i]) begin
                st_next.cnt[i] = '0;
            end else if (st_reg.state[i]) begin
                // Falling crossing, shorter hold
                if (int'(st_reg.cnt[i]) >= rail_seq_pkg::HOLD_FALL_CYCLES - 1) begin
                    st_next.state[i] = 1'b0;
                    st_next.cnt[i] = '0;
                end else begin
                    st_next.cnt[i] = st_reg.cnt[i] + 1'b1;
                end
            end else begin
                // Rising crossing, longer hold
                if (int'(st_reg.cnt[i]) >= rail_seq_pkg::HOLD_RISE_CYCLES - 1) begin
                    st_next.state[i] = 1'b1;
                    st_next.cnt[i] = '0;
                end else begin
                    st_next.cnt[i] = st_reg.cnt[i] + 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
endmodule
`default_nettype wire

// file: hw/four_channel_rail_sequencer.sv
`timescale 1ns/100ps
`default_nettype none
module four_channel_rail_sequencer #(
    parameter int REG_WINDOW = rail_seq_pkg::REG_WINDOW_CYCLES,
    parameter int STEP_UNIT  = rail_seq_pkg::STEP_UNIT_CYCLES
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       resetn,
    // Supply state
    input  wire logic       underVoltageLockout,
    // Requests
    input  wire logic       upRequest,
    input  wire logic       downRequestN,
    // Configuration
    input  wire logic [7:0] stepDelayCode,
    input  wire logic [2:0] usedChannelCount,
    // Rail side
    input  wire logic [3:0] rail_monitor_in,
    output logic      [3:0] channel_enable_out,
    // Status
    output logic            sequence_complete_flag,
    output logic            power_good_flag,
    output logic            faultN
);
    typedef enum logic [2:0] {
        WAIT_UP, UP_DELAY, UP_REGULATE, UP_DONE_DELAY,
        WAIT_DOWN, DOWN_DELAY, DOWN_DISCHARGE, DOWN_DONE_DELAY
    } seq_state_t;

    typedef struct packed {
        seq_state_t                       fsm;
        logic [1:0]                       ch;
        logic [1:0]                       lastCh;
        logic [rail_seq_pkg::TIMER_W-1:0] stepTimer;
        logic [rail_seq_pkg::TIMER_W-1:0] regTimer;
        logic [3:0]                       en;
        logic                             done;
        logic                             pgood;
        logic                             faultN;
        logic [1:0]                       upSync;
        logic [1:0]                       dnSync;
        logic                             upPrev;
        logic                             dnPrev;
        logic [1:0]                       uvSync;
        logic                             cfgTaken;
    } seq_reg_t;

    seq_reg_t st_reg;
    seq_reg_t st_next;
    rail_filter_if monIf ();
    logic [3:0] railOk;

    assign monIf.railRaw = rail_monitor_in;
    assign railOk = monIf.railInReg;

    rail_hold_filter holdFilter (
        .clk    (clk),
        .resetn (resetn),
        .mon    (monIf.filt)
    );

    // Step delay in cycles, code clamped to the documented range
    function automatic logic [rail_seq_pkg::TIMER_W-1:0] stepLoad(
        input logic [7:0] code);
        int c;
        c = int'(code);
        if (c < 1) c = 1;
        if (c > rail_seq_pkg::STEP_CODE_MAX) c = rail_seq_pkg::STEP_CODE_MAX;
        return rail_seq_pkg::TIMER_W'(c * STEP_UNIT - 1);
    endfunction

    // Highest used channel index
    function automatic logic [1:0] lastUsed(input logic [2:0] count);
        logic [1:0] r;
        r = rail_seq_pkg::LAST_CH;
        if (count <= 3'h1) r = rail_seq_pkg::FIRST_CH;
        else if (count < 3'h4) r = 2'(count - 3'h1);
        return r;
    endfunction

    logic upEdge;
    logic dnEdge;
    logic locked;
    assign upEdge = st_reg.upSync[1] && !st_reg.upPrev;
    assign dnEdge = !st_reg.dnSync[1] && st_reg.dnPrev;
    assign locked = st_reg.uvSync[1];

    always_comb begin
        st_next = st_reg;
        st_next.upSync = {st_reg.upSync[0], upRequest};
        st_next.dnSync = {st_reg.dnSync[0], downRequestN};
        st_next.uvSync = {st_reg.uvSync[0], underVoltageLockout};
        st_next.upPrev = st_reg.upSync[1];
        st_next.dnPrev = st_reg.dnSync[1];
        if (st_reg.stepTimer != '0) begin
            st_next.stepTimer = st_reg.stepTimer - 1'b1;
        end
        if (st_reg.regTimer != '0) begin
            st_next.regTimer = st_reg.regTimer - 1'b1;
        end
        // Unused channels latched once after reset; must stay static
        if (!st_reg.cfgTaken) begin
            st_next.cfgTaken = 1'b1;
            st_next.lastCh = lastUsed(usedChannelCount);
        end
        // An enable above a lower one that is off is out of order
        for (int i = 1; i < 4; i++) begin
            if (st_reg.en[i] && !st_reg.en[i-1]) begin
                st_next.faultN = 1'b0;
            end
        end
        unique case (st_reg.fsm)
            WAIT_UP: begin
                if (upEdge) begin
                    st_next.ch = rail_seq_pkg::FIRST_CH;
                    st_next.stepTimer = stepLoad(stepDelayCode);
                    st_next.fsm = UP_DELAY;
                end
            end
            UP_DELAY: begin
                if (dnEdge) begin
                    st_next.pgood = 1'b0;
                    st_next.stepTimer = stepLoad(stepDelayCode);
                    st_next.fsm = DOWN_DELAY;
                end else if (st_reg.stepTimer == '0) begin
                    st_next.en[st_reg.ch] = 1'b1;
                    st_next.regTimer = rail_seq_pkg::TIMER_W'(REG_WINDOW);
                    st_next.fsm = UP_REGULATE;
                end
            end
            UP_REGULATE: begin
                if (dnEdge) begin
                    st_next.pgood = 1'b0;
                    st_next.regTimer = '0;
                    st_next.stepTimer = stepLoad(stepDelayCode);
                    st_next.fsm = DOWN_DELAY;
                end else if (railOk[st_reg.ch]) begin
                    st_next.regTimer = '0;
                    st_next.stepTimer = stepLoad(stepDelayCode);
                    if (st_reg.ch == st_reg.lastCh) begin
                        st_next.fsm = UP_DONE_DELAY;
                    end else begin
                        st_next.ch = st_reg.ch + 1'b1;
                        st_next.fsm = UP_DELAY;
                    end
                end else if (st_reg.regTimer == '0) begin
                    // Window expired: reverse down from preceding channel
                    st_next.en[st_reg.ch] = 1'b0;
                    st_next.pgood = 1'b0;
                    st_next.stepTimer = stepLoad(stepDelayCode);
                    if (st_reg.ch == rail_seq_pkg::FIRST_CH) begin
                        st_next.fsm = DOWN_DONE_DELAY;
                    end else begin
                        st_next.ch = st_reg.ch - 1'b1;
                        st_next.fsm = DOWN_DELAY;
                    end
                end
            end
            UP_DONE_DELAY: begin
                if (dnEdge) begin
                    st_next.pgood = 1'b0;
                    st_next.stepTimer = stepLoad(stepDelayCode);
                    st_next.fsm = DOWN_DELAY;
                end else if (st_reg.stepTimer == '0) begin
                    st_next.done = 1'b1;
                    st_next.pgood = 1'b1;
                    st_next.fsm = WAIT_DOWN;
                end
            end
            WAIT_DOWN: begin
                if (dnEdge) begin
                    st_next.pgood = 1'b0;
                    st_next.ch = st_reg.lastCh;
                    st_next.stepTimer = stepLoad(stepDelayCode);
                    st_next.fsm = DOWN_DELAY;
                end
            end
            DOWN_DELAY: begin
                // Channel index held from the aborted up or set to last
                if (st_reg.stepTimer == '0) begin
                    st_next.en[st_reg.ch] = 1'b0;
                    st_next.fsm = DOWN_DISCHARGE;
                end
            end
            DOWN_DISCHARGE: begin
                // No window while rails discharge
                if (!railOk[st_reg.ch]) begin
                    st_next.stepTimer = stepLoad(stepDelayCode);
                    if (st_reg.ch == rail_seq_pkg::FIRST_CH) begin
                        st_next.fsm = DOWN_DONE_DELAY;
                    end else begin
                        st_next.ch = st_reg.ch - 1'b1;
                        st_next.fsm = DOWN_DELAY;
                    end
                end
            end
            DOWN_DONE_DELAY: begin
                if (st_reg.stepTimer == '0) begin
                    st_next.done = 1'b0;
                    st_next.fsm = WAIT_UP;
                end
            end
        endcase
        // Lockout forces enables, complete and power good low (faultN untouched) and parks the sequencer
        if (locked) begin
            st_next.fsm = WAIT_UP;
            st_next.en = '0;
            st_next.done = 1'b0;
            st_next.pgood = 1'b0;
            st_next.stepTimer = '0;
            st_next.regTimer = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            // Fault output idles high straight from its flop
            st_reg <= '{fsm: WAIT_UP, dnSync: 2'h3, dnPrev: 1'b1, faultN: 1'b1,
                        lastCh: rail_seq_pkg::LAST_CH, default: '0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign channel_enable_out = st_reg.en;
    assign sequence_complete_flag = st_reg.done;
    assign power_good_flag = st_reg.pgood;
    assign faultN = st_reg.faultN;
endmodule
`default_nettype wire

// file: test/rail_seq_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module rail_seq_asserts #(
    parameter int REG_WINDOW = 80
) (
    input wire logic       clk,
    input wire logic       resetn,
    input wire logic       underVoltageLockout,
    input wire logic       upRequest,
    input wire logic       downRequestN,
    input wire logic [7:0] stepDelayCode,
    input wire logic [2:0] usedChannelCount,
    input wire logic [3:0] rail_monitor_in,
    input wire logic [3:0] channel_enable_out,
    input wire logic       sequence_complete_flag,
    input wire logic       power_good_flag,
    input wire logic       faultN
);
    localparam int FAULT_BOUND = 43;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    logic        orderOk;
    logic [19:0] lagCnt_reg;
    assign orderOk = (channel_enable_out & (channel_enable_out + 4'h1)) == 4'h0;
    // Cycles an enabled rail has stayed below its on level
    always_ff @(posedge clk) begin
        if (!resetn || (channel_enable_out & ~rail_monitor_in) == 4'h0) begin
            lagCnt_reg <= 20'h0;
        end else begin
            lagCnt_reg <= lagCnt_reg + 20'h1;
        end
    end
    sequence downCmd;
        $fell(downRequestN) && power_good_flag;
    endsequence
    sequence goodDrops;
        ##[1:6] !power_good_flag;
    endsequence
    reset_clears_a: assert property (disable iff (1'b0) !resetn |=> channel_enable_out == 4'h0 && !power_good_flag && !sequence_complete_flag && faultN) else $error("outputs not cleared by reset");
    enable_order_a: assert property (orderOk) else $error("enables out of order");
    fault_raise_a: assert property (!orderOk |-> ##[0:FAULT_BOUND] !faultN) else $error("fault output late");
    lockout_low_a: assert property (underVoltageLockout [*4] |-> channel_enable_out == 4'h0 && !power_good_flag && !sequence_complete_flag) else $error("outputs active in lockout");
    good_rise_a: assert property ($rose(power_good_flag) |-> sequence_complete_flag && channel_enable_out[0] && rail_monitor_in[0]) else $error("power good without complete");
    complete_fall_a: assert property ($fell(sequence_complete_flag) && !underVoltageLockout |-> channel_enable_out == 4'h0 && !$past(rail_monitor_in[0], 10)) else $error("complete fell early");
    good_drop_a: assert property (downCmd |-> goodDrops) else $error("power good kept after down");
    window_bound_a: assert property (lagCnt_reg <= 20'(REG_WINDOW + 8)) else $error("regulation window overrun");
    step_up_a: assert property ($rose(channel_enable_out[1]) |-> $past(rail_monitor_in[0], 16)) else $error("enable 2 before rail 1 held");
    step_down_a: assert property ($fell(channel_enable_out[2]) && !underVoltageLockout |-> (usedChannelCount < 3'h4 || !$past(rail_monitor_in[3], 10))) else $error("enable 3 fell before rail 4 off");
endmodule
bind four_channel_rail_sequencer rail_seq_asserts #(.REG_WINDOW(REG_WINDOW))
    i_rail_seq_asserts (.clk(clk), .resetn(resetn),
    .underVoltageLockout(underVoltageLockout), .upRequest(upRequest),
    .downRequestN(downRequestN), .stepDelayCode(stepDelayCode),
    .usedChannelCount(usedChannelCount), .rail_monitor_in(rail_monitor_in),
    .channel_enable_out(channel_enable_out),
    .sequence_complete_flag(sequence_complete_flag),
    .power_good_flag(power_good_flag), .faultN(faultN));
`default_nettype wire

// file: test/rail_model.sv
`timescale 1ns/100ps
`default_nettype none
module rail_model #(
    parameter int RISE = 40,
    parameter int FALL = 100
) (
    input  wire logic       clk,
    input  wire logic [3:0] enable,
    input  wire logic [3:0] deadMask,
    input  wire logic [3:0] tiedMask,
    output logic      [3:0] monitor
);
    int cnt [4] = '{0, 0, 0, 0};
    initial monitor = 4'h0;
    always @(posedge clk) begin
        for (int i = 0; i < 4; i++) begin
            if (tiedMask[i]) begin
                monitor[i] <= 1'b1;
            end else if (enable[i] == monitor[i] || (enable[i] && deadMask[i])) begin
                cnt[i] <= 0;
            end else if (cnt[i] >= (enable[i] ? RISE : FALL)) begin
                monitor[i] <= enable[i];
                cnt[i] <= 0;
            end else begin
                cnt[i] <= cnt[i] + 1;
            end
        end
    end
endmodule
`default_nettype wire

// file: test/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    localparam int WIN = 80;
    localparam int UNIT = 4;
    logic       clk = 1'b0;
    logic       resetn = 1'b0;
    logic       lockout = 1'b0;
    logic       upReq = 1'b0;
    logic       downReqN = 1'b1;
    logic [7:0] code = 8'h01;
    logic [2:0] used = 3'h4;
    logic [3:0] deadMask = 4'h0;
    logic [3:0] tiedMask = 4'h0;
    logic [3:0] mon;
    logic [3:0] en;
    logic       done;
    logic       good;
    logic       faultN;
    int         fail_count = 0;
    int         num_checks = 0;
    always #50 clk = ~clk;
    four_channel_rail_sequencer #(.REG_WINDOW(WIN), .STEP_UNIT(UNIT))
        i_four_channel_rail_sequencer (.clk(clk), .resetn(resetn),
        .underVoltageLockout(lockout), .upRequest(upReq),
        .downRequestN(downReqN), .stepDelayCode(code),
        .usedChannelCount(used), .rail_monitor_in(mon),
        .channel_enable_out(en), .sequence_complete_flag(done),
        .power_good_flag(good), .faultN(faultN));
    // Slow discharge outlasts the window; per-rail rise fits only if it restarts
    rail_model #(.RISE(40), .FALL(WIN + 20)) i_rail_model (.clk(clk),
        .enable(en), .deadMask(deadMask), .tiedMask(tiedMask), .monitor(mon));
    function automatic logic [3:0] therm(input int k);
        return 4'((1 << k) - 1);
    endfunction
    function automatic int stepOf(input logic [7:0] c);
        return (c == 8'h00 ? 1 : (c > 8'h64 ? 100 : int'(c))) * UNIT;
    endfunction
    function automatic logic inWin(input int n, input int lo, input int hi);
        return n >= lo && n <= hi;
    endfunction
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task waitOut(input logic [5:0] want, output int n);
        n = 0;
        while ({done, good, en} !== want) begin
            @(negedge clk);
            n++;
            if (n > 3000) begin
                check("output wait", {done, good, en}, want);
                test_done();
            end
        end
    endtask
    task startRun(input int uc, input logic [3:0] dead);
        resetn = 1'b0;
        upReq = 1'b0;
        downReqN = 1'b1;
        used = 3'(uc);
        tiedMask = ~therm(uc);
        deadMask = dead;
        repeat (5) @(negedge clk);
        resetn = 1'b1;
        @(negedge clk);
        check("idle outputs", {faultN, done, good, en}, 7'h40);
    endtask
    task rampUp(input int upTo, input logic [1:0] flags);
        int n;
        upReq = 1'b1;
        for (int k = 1; k <= upTo; k++) begin
            waitOut({2'b00, therm(k)}, n);
            if (k == 1) check("first enable delay", inWin(n, stepOf(code) + 2, stepOf(code) + 8), 1);
        end
        waitOut({flags, therm(upTo)}, n);
    endtask
    // Lead is the cycles already spent since the down command or abort
    task rampDown(input int uc, input logic top, input int lead);
        int n;
        for (int k = uc - 1; k >= 0; k--) begin
            waitOut({top, 1'b0, therm(k)}, n);
            if (k == uc - 1) check("top enable delay", inWin(n + lead, stepOf(code), stepOf(code) + 6), 1);
        end
        waitOut(6'h00, n);
        if (top) check("complete after rail off", n >= stepOf(code) + 16, 1);
    endtask
    initial begin
        int n;
        int uc;
        int d;
        void'($urandom(59));
        startRun(4, 4'h0);
        repeat (28000) @(negedge clk);
        for (int i = 0; i < 4; i++) begin
            uc = (i < 2) ? 4 : 1 + $urandom % 4;
            if (i > 0) startRun(uc, 4'h0);
            code = (i == 0) ? 8'h00 : ((i == 1) ? 8'hff : 8'(1 + $urandom % 8));
            downReqN = 1'b1;
            rampUp(uc, 2'b11);
            check("fault idle", faultN, 1'b1);
            upReq = 1'b0;
            repeat (10) @(negedge clk);
            upReq = 1'b1;
            repeat (20) @(negedge clk);
            check("second up ignored", {done, good, en}, {2'b11, therm(uc)});
            upReq = 1'b0;
            downReqN = 1'b0;
            n = 0;
            waitOut({2'b10, therm(uc)}, n);
            check("power good drop", n <= 6, 1);
            rampDown(uc, 1'b1, n);
        end
        d = 1 + $urandom % 3;
        startRun(4, 4'h1 << d);
        rampUp(d + 1, 2'b00);
        waitOut({2'b00, therm(d)}, n);
        check("window abort", inWin(n, WIN - 2, WIN + 8), 1);
        rampDown(d, 1'b0, 0);
        startRun(4, 4'h0);
        rampUp(2, 2'b00);
        lockout = 1'b1;
        repeat (6) @(negedge clk);
        check("lockout outputs", {done, good, en}, 6'h00);
        lockout = 1'b0;
        test_done();
    end
endmodule
`default_nettype wire
